// >>> rtl/nvram_spi_pkg.sv
// Constants, types and reset values for the serial nonvolatile memory front end
// Summary of operation
// - Chip select high: standby, other inputs ignored, serial output released.
// - Input bits taken on rising clock edge, output changes on falling edge.
// - Fully static interface, any serial clock rate from zero to 15 MHz.
// - Pause low suspends operation; clock and select transitions are ignored.
// - Status lock input low refuses status register writes.
// - Serial input read only at rising clock edges, ignored otherwise.
// - Serial output driven only while returning read data, never during pause.
// - Memory holds 2,048 locations of 8 bits each.
// - Two address bytes follow op-code; upper 5 bits ignored, low 11 used.
// - Each data byte is written at its last bit; never busy.
// - Clock modes 0 and 3 supported, others not.
// - Select low gates serial clock inward; select high clock does nothing.
// - Power-on reset initialises the logic; no other power management.
// - First byte is the op-code; one op-code per select assertion.
// - Decode set latch, clear latch, read/write status, read/write memory.
// - Transfers are 8-bit groups, most significant bit first.
// - Write latch cleared at reset, by clear command and at deselect after a completed write.
package nvram_spi_pkg;

  // ==========================================================
  // Array geometry
  localparam int MEM_DEPTH = 2048;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;

  // ==========================================================
  // Link rate: sampled clock needs several samples per phase
  localparam int CLK_MHZ = 200;
  localparam int SCK_MAX_MHZ = 15;
  localparam int SAMPLES_PER_SCK = CLK_MHZ / SCK_MAX_MHZ;

  // ==========================================================
  // Op-codes
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_MEM = 8'h03;
  localparam logic [7:0] OP_WRITE_MEM = 8'h02;

  // ==========================================================
  // Status byte layout
  localparam int WRITE_LATCH_FLAG_BIT = 1;
  localparam logic [7:0] STATUS_WRITE_MASK = 8'h8C;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ==========================================================
  // Types
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } pins_t;

  localparam pins_t PINS_RESET = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};

  typedef enum logic [6:0] {
    ST_OPCODE = 7'h01,
    ST_ADDR = 7'h02,
    ST_WDATA = 7'h04,
    ST_RDATA = 7'h08,
    ST_STAT_W = 7'h10,
    ST_STAT_R = 7'h20,
    ST_IGNORE = 7'h40
  } phase_t;

  typedef struct packed {
    pins_t pin1;
    pins_t pin2;
    logic sck_prev;
    logic cs_act;
    phase_t phase;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [BIT_CNT_W-1:0] out_cnt;
    logic [DATA_W-1:0] rx;
    logic [DATA_W-1:0] tx;
    logic [ADDR_W-1:0] addr;
    logic addr_low;
    logic rd_op;
    logic load_tx;
    logic so_on;
    logic so;
    logic so_oe_n;
    logic write_latch_flag;
    logic wr_done;
    logic [DATA_W-1:0] status_bits;
  } core_t;

  localparam core_t CORE_RESET = '{
    pin1: PINS_RESET,
    pin2: PINS_RESET,
    sck_prev: 1'b0,
    cs_act: 1'b0,
    phase: ST_OPCODE,
    bit_cnt: 3'h0,
    out_cnt: 3'h0,
    rx: 8'h00,
    tx: 8'h00,
    addr: 11'h000,
    addr_low: 1'b0,
    rd_op: 1'b0,
    load_tx: 1'b0,
    so_on: 1'b0,
    so: 1'b0,
    so_oe_n: 1'b1,
    write_latch_flag: 1'b0,
    wr_done: 1'b0,
    status_bits: STATUS_RESET
  };

endpackage : nvram_spi_pkg

// >>> rtl/serial_nv_memory_spi_slave.sv
// Serial memory front end with its byte array, run on a sampled serial clock
`timescale 1ns/1ps
`default_nettype none

module serial_nv_memory_spi_slave (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  output logic o_so,
  output logic o_so_oe_n
);

  // ==========================================================
  // Storage
  // byte array
  logic [nvram_spi_pkg::DATA_W-1:0] mem [nvram_spi_pkg::MEM_DEPTH];

  nvram_spi_pkg::core_t s_reg;
  nvram_spi_pkg::core_t s_next;
  nvram_spi_pkg::pins_t pins_in;
  logic mem_we;
  logic [nvram_spi_pkg::ADDR_W-1:0] mem_waddr;
  logic [nvram_spi_pkg::DATA_W-1:0] mem_wdata;
  logic [nvram_spi_pkg::DATA_W-1:0] mem_rdata;

  // Status byte as seen by a read, latch flag merged in
  function automatic logic [7:0] status_view(input logic [7:0] bits, input logic flag);
    logic [7:0] v;
    v = bits & nvram_spi_pkg::STATUS_WRITE_MASK;
    v[nvram_spi_pkg::WRITE_LATCH_FLAG_BIT] = flag;
    return v;
  endfunction : status_view

  assign pins_in = '{cs_n: i_cs_n, sck: i_sck, si: i_si, hold_n: i_hold_n, wp_n: i_wp_n};
  assign mem_rdata = mem[s_reg.addr];

  // ==========================================================
  // Next state
  always_comb begin
    logic active;
    logic sck_rise;
    logic sck_fall;
    logic [7:0] rx_byte;
    active = 1'b0;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    rx_byte = 8'h00;
    s_next = s_reg;
    mem_we = 1'b0;
    mem_waddr = s_reg.addr;
    mem_wdata = 8'h00;

    // Pins reach logic only through two flops; first flop feeds only the second
    s_next.pin1 = pins_in;
    s_next.pin2 = s_reg.pin1;
    s_next.sck_prev = s_reg.pin2.sck;

    if (s_reg.pin2.hold_n) begin
      s_next.cs_act = ~s_reg.pin2.cs_n;
    end

    // clock gated by select and pause
    active = s_reg.cs_act & s_reg.pin2.hold_n;
    // edge detect works for either idle level
    sck_rise = active & s_reg.pin2.sck & ~s_reg.sck_prev;
    sck_fall = active & ~s_reg.pin2.sck & s_reg.sck_prev;
    // data bit only used with a rising edge
    rx_byte = {s_reg.rx[6:0], s_reg.pin2.si};

    if (!s_reg.cs_act) begin
      s_next.phase = nvram_spi_pkg::ST_OPCODE;
      s_next.bit_cnt = 3'h0;
      s_next.out_cnt = 3'h0;
      s_next.addr_low = 1'b0;
      s_next.rd_op = 1'b0;
      s_next.load_tx = 1'b0;
      s_next.so_on = 1'b0;
      // latch cleared once a write has completed
      if (s_reg.wr_done) begin
        s_next.write_latch_flag = 1'b0;
        s_next.wr_done = 1'b0;
      end
    end else begin
      // Array read deferred one cycle so the address is registered first
      if (s_reg.load_tx) begin
        s_next.load_tx = 1'b0;
        s_next.tx = mem_rdata;
        s_next.addr = s_reg.addr + nvram_spi_pkg::ADDR_ONE;
      end

      // inputs shifted in on rising edge
      if (sck_rise) begin
        // MSB first, 8 bits a byte
        s_next.rx = rx_byte;
        s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
        if (s_reg.bit_cnt == nvram_spi_pkg::BIT_LAST) begin
          case (s_reg.phase)
            nvram_spi_pkg::ST_OPCODE: begin
              // one op-code, later bytes go to its phase
              case (rx_byte)
                nvram_spi_pkg::OP_SET_WRITE_LATCH: begin
                  s_next.write_latch_flag = 1'b1;
                  s_next.phase = nvram_spi_pkg::ST_IGNORE;
                end
                nvram_spi_pkg::OP_CLEAR_WRITE_LATCH: begin
                  s_next.write_latch_flag = 1'b0;
                  s_next.phase = nvram_spi_pkg::ST_IGNORE;
                end
                nvram_spi_pkg::OP_READ_STATUS: begin
                  s_next.tx = status_view(s_reg.status_bits, s_reg.write_latch_flag);
                  s_next.phase = nvram_spi_pkg::ST_STAT_R;
                end
                nvram_spi_pkg::OP_WRITE_STATUS: begin
                  s_next.phase = nvram_spi_pkg::ST_STAT_W;
                end
                nvram_spi_pkg::OP_READ_MEM: begin
                  s_next.rd_op = 1'b1;
                  s_next.phase = nvram_spi_pkg::ST_ADDR;
                end
                nvram_spi_pkg::OP_WRITE_MEM: begin
                  s_next.rd_op = 1'b0;
                  s_next.phase = nvram_spi_pkg::ST_ADDR;
                end
                default: begin
                  s_next.phase = nvram_spi_pkg::ST_IGNORE;
                end
              endcase
            end
            nvram_spi_pkg::ST_ADDR: begin
              if (!s_reg.addr_low) begin
                s_next.addr = {rx_byte[2:0], s_reg.addr[7:0]};
                s_next.addr_low = 1'b1;
              end else begin
                s_next.addr = {s_reg.addr[10:8], rx_byte};
                if (s_reg.rd_op) begin
                  s_next.load_tx = 1'b1;
                  s_next.phase = nvram_spi_pkg::ST_RDATA;
                end else begin
                  s_next.phase = nvram_spi_pkg::ST_WDATA;
                end
              end
            end
            nvram_spi_pkg::ST_WDATA: begin
              // byte committed on its last bit
              if (s_reg.write_latch_flag) begin
                mem_we = 1'b1;
                mem_wdata = rx_byte;
                s_next.wr_done = 1'b1;
              end
              s_next.addr = s_reg.addr + nvram_spi_pkg::ADDR_ONE;
            end
            nvram_spi_pkg::ST_STAT_W: begin
              if (s_reg.write_latch_flag && s_reg.pin2.wp_n) begin
                s_next.status_bits = rx_byte & nvram_spi_pkg::STATUS_WRITE_MASK;
                s_next.wr_done = 1'b1;
              end
              s_next.phase = nvram_spi_pkg::ST_IGNORE;
            end
            default: begin
              s_next.phase = s_reg.phase;
            end
          endcase
        end
      end

      if (sck_fall && (s_reg.phase == nvram_spi_pkg::ST_RDATA ||
                       s_reg.phase == nvram_spi_pkg::ST_STAT_R)) begin
        s_next.so_on = 1'b1;
        s_next.so = s_reg.tx[7];
        s_next.out_cnt = s_reg.out_cnt + 3'h1;
        if (s_reg.out_cnt == nvram_spi_pkg::BIT_LAST) begin
          if (s_reg.phase == nvram_spi_pkg::ST_RDATA) begin
            s_next.load_tx = 1'b1;
          end else begin
            s_next.tx = status_view(s_reg.status_bits, s_reg.write_latch_flag);
          end
        end else begin
          s_next.tx = {s_reg.tx[6:0], 1'b0};
        end
      end
    end

    // output released outside read data and during pause
    s_next.so_oe_n = ~(s_next.so_on & s_next.cs_act & s_reg.pin2.hold_n);
  end

  // ==========================================================
  // State register
  // power-on reset sets all control state
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_reg <= nvram_spi_pkg::CORE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Array keeps contents through reset, as a nonvolatile store would
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // static design, clock may stop anywhere
  assign o_so = s_reg.so;
  assign o_so_oe_n = s_reg.so_oe_n;

endmodule : serial_nv_memory_spi_slave

`default_nettype wire

// >>> tb/nvram_spi_sva.sv
// Pin checker for the serial memory front end
`timescale 1ns/1ps
`default_nettype none
module nvram_spi_sva (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_hold_n,
  input wire logic o_so,
  input wire logic o_so_oe_n
);
  // ====
  // Cycles since a clock fall; saturates so idle gaps never wrap
  logic sck_reg;
  logic [3:0] age_reg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sck_reg <= 1'b0;
      age_reg <= 4'hF;
    end else begin
      sck_reg <= i_sck;
      if (sck_reg && !i_sck) begin
        age_reg <= 4'h0;
      end else if (age_reg != 4'hF) begin
        age_reg <= age_reg + 4'h1;
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ====
  // release on deselect and pause, output timing and cause
  property p_cs_release; $rose(i_cs_n) |-> ##[1:6] o_so_oe_n; endproperty
  a_cs_release: assert property (p_cs_release) else $error("so kept after deselect");
  property p_cs_idle; i_cs_n [*8] |-> o_so_oe_n && $stable(o_so); endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("so moved while unselected");
  property p_hold_release; $fell(i_hold_n) |-> ##[1:6] o_so_oe_n; endproperty
  a_hold_release: assert property (p_hold_release) else $error("so kept in pause");
  property p_hold_idle; !i_hold_n [*8] |-> o_so_oe_n && $stable(o_so); endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("so moved in pause");
  property p_so_edge; !o_so_oe_n && $changed(o_so) |-> age_reg <= 4'h6; endproperty
  a_so_edge: assert property (p_so_edge) else $error("so changed off a fall");
  property p_oe_edge; $fell(o_so_oe_n) && $past(i_hold_n, 8) |-> age_reg <= 4'h7; endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("drive began off a fall");
  property p_oe_cause; $fell(o_so_oe_n) |-> !$past(i_cs_n, 2) && $past(i_hold_n, 2); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive without select");
  property p_oe_drop; $rose(o_so_oe_n) |-> $past(i_cs_n, 2) || !$past(i_hold_n, 2); endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("drive dropped mid read");
endmodule : nvram_spi_sva
bind serial_nv_memory_spi_slave nvram_spi_sva u_sva (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_cs_n(i_cs_n), .i_sck(i_sck), .i_hold_n(i_hold_n), .o_so(o_so), .o_so_oe_n(o_so_oe_n));
`default_nettype wire

// >>> tb/spi_host_model.sv
// Bus master model driving the serial memory pins
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic i_clk,
  input wire logic i_so,
  input wire logic i_so_oe_n,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  output logic o_hold_n
);
  // ====
  // Idle clock level: high for mode 3
  logic idle_hi;
  initial begin
    idle_hi = 1'b0;
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
    o_hold_n = 1'b1;
  end
  task start();
    @(negedge i_clk);
    o_sck = idle_hi;
    #48;
    o_cs_n = 1'b0;
    #48;
  endtask : start
  task stop();
    o_sck = idle_hi;
    #24;
    o_cs_n = 1'b1;
    o_si = ~o_si;
    #48;
  endtask : stop
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_sck = 1'b0;
      o_si = tx[i];
      #24;
      o_sck = 1'b1;
      #24;
      // Released line reads as garbage
      rx[i] = i_so_oe_n ? ~i_so : i_so;
    end
  endtask : xfer
  task pause(output logic oe_n);
    o_sck = 1'b0;
    #24;
    o_hold_n = 1'b0;
    #24;
    repeat (2) begin
      o_sck = 1'b1;
      #24;
      o_sck = 1'b0;
      #24;
    end
    oe_n = i_so_oe_n;
    o_hold_n = 1'b1;
    #48;
  endtask : pause
endmodule : spi_host_model
`default_nettype wire

// >>> tb/serial_nv_memory_spi_slave_tb.sv
// Self-checking bench for the serial memory front end
`timescale 1ns/1ps
`default_nettype none
module serial_nv_memory_spi_slave_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic wp_n = 1'b1;
  logic cs_n, sck, si, hold_n, so, so_oe_n, oe, latch_m;
  logic [7:0] mem_m [2048];
  logic [7:0] stat_m, d0, d1;
  logic [15:0] a;
  logic [31:0] rnd;
  integer seed = 32'h9b5a;
  integer miscompares = 0;
  integer comparisons = 0;
  always #2.5 clk = ~clk;
  serial_nv_memory_spi_slave u_dut (.i_clk(clk), .i_arst_n(arst_n), .i_cs_n(cs_n),
    .i_sck(sck), .i_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so), .o_so_oe_n(so_oe_n));
  spi_host_model u_host (.i_clk(clk), .i_so(so), .i_so_oe_n(so_oe_n), .o_cs_n(cs_n),
    .o_sck(sck), .o_si(si), .o_hold_n(hold_n));
  // ====
  function automatic logic [7:0] exp_stat();
    return (stat_m & nvram_spi_pkg::STATUS_WRITE_MASK) | {6'h00, latch_m, 1'b0};
  endfunction : exp_stat
  task check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task frame(input logic [7:0] op, input logic [7:0] b, output logic [7:0] r);
    u_host.start();
    u_host.xfer(op, r);
    u_host.xfer(b, r);
    u_host.stop();
  endtask : frame
  task rd_stat();
    logic [7:0] r;
    frame(nvram_spi_pkg::OP_READ_STATUS, 8'h00, r);
    check("status", exp_stat(), r);
  endtask : rd_stat
  task mem_op(input logic [7:0] op, input logic hold);
    logic [7:0] r0, r1;
    u_host.start();
    u_host.xfer(op, r0);
    u_host.xfer(a[15:8], r0);
    u_host.xfer(a[7:0], r0);
    u_host.xfer(d0, r0);
    if (hold) u_host.pause(oe);
    u_host.xfer(d1, r1);
    u_host.stop();
    if (op == nvram_spi_pkg::OP_READ_MEM) begin
      check("byte0", mem_m[a[10:0]], r0);
      check("byte1", mem_m[a[10:0] + 11'h001], r1);
    end
  endtask : mem_op
  initial begin
    #150000;
    miscompares++;
    stop_test();
  end
  initial begin
    latch_m = 1'b0;
    stat_m = nvram_spi_pkg::STATUS_RESET;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    rd_stat();
    for (int i = 0; i < 6; i++) begin
      rnd = $random(seed);
      u_host.idle_hi = rnd[0];
      if (i != 3) a = (i == 0) ? 16'hFFFF : rnd[31:16];
      {d0, d1} = rnd[15:0];
      if (i != 3) frame(nvram_spi_pkg::OP_SET_WRITE_LATCH, 8'h00, d0);
      latch_m = (i != 3);
      {d0, d1} = rnd[15:0];
      mem_op(nvram_spi_pkg::OP_WRITE_MEM, 1'b0);
      if (latch_m) {mem_m[a[10:0]], mem_m[a[10:0] + 11'h001]} = {d0, d1};
      latch_m = 1'b0;
      a = a ^ 16'hF800;
      mem_op(nvram_spi_pkg::OP_READ_MEM, i == 2);
      if (i == 2) check("pause release", 8'h01, {7'h00, oe});
      rd_stat();
      $display("test %0d done", i);
    end
    frame(nvram_spi_pkg::OP_SET_WRITE_LATCH, 8'h00, d0);
    latch_m = 1'b1;
    rd_stat();
    frame(nvram_spi_pkg::OP_CLEAR_WRITE_LATCH, 8'h00, d0);
    latch_m = 1'b0;
    rd_stat();
    frame(nvram_spi_pkg::OP_SET_WRITE_LATCH, 8'h00, d0);
    latch_m = 1'b1;
    wp_n = 1'b0;
    frame(nvram_spi_pkg::OP_WRITE_STATUS, 8'hFF, d0);
    rd_stat();
    wp_n = 1'b1;
    frame(nvram_spi_pkg::OP_WRITE_STATUS, 8'hFF, d0);
    stat_m = 8'hFF;
    latch_m = 1'b0;
    rd_stat();
    $display("test status done");
    stop_test();
  end
endmodule : serial_nv_memory_spi_slave_tb
`default_nettype wire
